// File: inc/pswg_defines.vh
`ifndef PSWG_DEFINES_VH
`define PSWG_DEFINES_VH

// ****************************************************************
// Widths
// ****************************************************************
`define PSWG_CMP_W          12
`define PSWG_CNT_W          13
`define PSWG_CFG_W          8

// ****************************************************************
// Ramp modes
// ****************************************************************
`define PSWG_MODE_FOUR      2'h0
`define PSWG_MODE_TWO       2'h1
`define PSWG_MODE_ONE       2'h2
`define PSWG_MODE_CENTER    2'h3

// ****************************************************************
// Ramp indexes
// ****************************************************************
`define PSWG_RAMP_0         2'h0
`define PSWG_RAMP_1         2'h1
`define PSWG_RAMP_2         2'h2
`define PSWG_RAMP_3         2'h3

// ****************************************************************
// Timing offsets, in generator clock periods
// ****************************************************************
// Four-ramp dead ramp counts 0..set+1, giving set+2 periods
`define PSWG_FOUR_DT_ADD    13'h0001
`define PSWG_CNT_ONE        13'h0001

// ****************************************************************
// Output configuration register fields
// ****************************************************************
`define PSWG_OCFG_POL_A     0
`define PSWG_OCFG_POL_B     1
`define PSWG_OCFG_SEL_DUP2  2
`define PSWG_OCFG_SEL_DUP3  3
`define PSWG_OCFG_EN_A      4
`define PSWG_OCFG_EN_B      5
`define PSWG_OCFG_EN_DUP2   6
`define PSWG_OCFG_EN_DUP3   7

// ****************************************************************
// Event flag positions and reset values
// ****************************************************************
`define PSWG_FLAG_OVF       0
`define PSWG_FLAG_FAULT     1
`define PSWG_FLAG_CAPT      2
`define PSWG_CMP_RST        12'h0000
`define PSWG_CFG_RST        8'h00

`endif

// File: logic/pswg_ramp.v
`timescale 1ns/1ps
`include "pswg_defines.vh"

module pswg_ramp #(
  parameter CW = 12
) (
  // Clock and reset
  input  wire          clk,
  input  wire          reset,
  // Control
  input  wire          run,
  input  wire [1:0]    mode,
  // Active compare values
  input  wire [CW-1:0] set_a,
  input  wire [CW-1:0] reset_a,
  input  wire [CW-1:0] set_b,
  input  wire [CW-1:0] reset_b,
  // Status
  output wire [CW-1:0] cnt_val,
  output wire [1:0]    ramp,
  output reg           eoc,
  output reg           wave_a,
  output reg           wave_b
);

  reg [CW:0] cnt_q;
  reg [1:0]  ramp_q;
  reg [CW:0] top;
  reg        last;
  reg [1:0]  next_ramp;
  reg [CW:0] dn_val;

  wire [CW:0] sa = {1'b0, set_a};
  wire [CW:0] ra = {1'b0, reset_a};
  wire [CW:0] sb = {1'b0, set_b};
  wire [CW:0] rb = {1'b0, reset_b};

  assign ramp    = ramp_q;
  assign cnt_val = dn_val[CW-1:0];

  // ****************************************************************
  // Ramp limits and raw waveforms per mode
  // ****************************************************************
  always @* begin
    top       = rb;
    last      = 1'b1;
    next_ramp = `PSWG_RAMP_0;
    dn_val    = cnt_q;
    wave_a    = 1'b0;
    wave_b    = 1'b0;
    case (mode)
      `PSWG_MODE_FOUR: begin
        case (ramp_q)
          `PSWG_RAMP_0: begin
            top       = sa + `PSWG_FOUR_DT_ADD;
            last      = 1'b0;
            next_ramp = (ra == {(CW+1){1'b0}}) ? `PSWG_RAMP_2 : `PSWG_RAMP_1;
          end
          `PSWG_RAMP_1: begin
            top       = ra - `PSWG_CNT_ONE;
            last      = 1'b0;
            next_ramp = `PSWG_RAMP_2;
            wave_a    = 1'b1;
          end
          `PSWG_RAMP_2: begin
            top       = sb + `PSWG_FOUR_DT_ADD;
            last      = (rb == {(CW+1){1'b0}});
            next_ramp = `PSWG_RAMP_3;
          end
          default: begin
            top       = rb - `PSWG_CNT_ONE;
            wave_b    = 1'b1;
          end
        endcase
      end
      `PSWG_MODE_TWO: begin
        if (ramp_q == `PSWG_RAMP_0) begin
          top       = ra;
          last      = 1'b0;
          next_ramp = `PSWG_RAMP_1;
          wave_a    = (cnt_q > sa);
        end else begin
          wave_b    = (cnt_q > sb);
        end
      end
      `PSWG_MODE_ONE: begin
        // Both compares run on one ramp, so the outputs may overlap
        wave_a = (cnt_q > sa) && (cnt_q <= ra);
        wave_b = (cnt_q > sb) && (cnt_q <= rb);
      end
      default: begin
        // Down ramp is an up count mirrored, so the restart never needs the new top
        if (ramp_q == `PSWG_RAMP_0) begin
          dn_val    = rb - cnt_q;
          last      = 1'b0;
          next_ramp = `PSWG_RAMP_1;
        end
        wave_a = (dn_val < sa);
        wave_b = (dn_val >= sb);
      end
    endcase
    wave_a = wave_a & run;
    wave_b = wave_b & run;
    eoc    = run & (cnt_q == top) & last;
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  always @(posedge clk) begin
    if (reset || !run) begin
      cnt_q  <= {(CW+1){1'b0}};
      ramp_q <= `PSWG_RAMP_0;
    end else if (cnt_q == top) begin
      cnt_q  <= {(CW+1){1'b0}};
      ramp_q <= last ? `PSWG_RAMP_0 : next_ramp;
    end else begin
      cnt_q  <= cnt_q + `PSWG_CNT_ONE;
    end
  end

endmodule // pswg_ramp

// File: logic/pswg_shadow.v
`timescale 1ns/1ps
`include "pswg_defines.vh"

module pswg_shadow #(
  parameter W   = 12,
  parameter RST = 0
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Software write side
  input  wire         wr,
  input  wire [W-1:0] wdata,
  // Coherent transfer
  input  wire         load,
  input  wire [W-1:0] load_data,
  // Values
  output wire [W-1:0] staged,
  output wire [W-1:0] active
);

  reg [W-1:0] staged_q;
  reg [W-1:0] active_q;

  assign staged = staged_q;
  assign active = active_q;

  always @(posedge clk) begin
    if (reset) begin
      staged_q <= RST[W-1:0];
      active_q <= RST[W-1:0];
    end else begin
      if (wr) begin
        staged_q <= wdata;
      end
      // Load data is chosen by the parent so part A can mirror part B
      if (load) begin
        active_q <= load_data;
      end
    end
  end

endmodule // pswg_shadow

// File: logic/pswg_top.v
`timescale 1ns/1ps
`include "pswg_defines.vh"

module pswg_top #(
  parameter CW = 12
) (
  // Clock and reset
  input  wire          CLK,
  input  wire          RESET,
  // Control bits
  input  wire          RUN,
  input  wire [1:0]    MODE,
  input  wire          FIFTY_PERCENT,
  input  wire          LOCK,
  input  wire          AUTO_UPDATE_HOLD,
  // Waveform register writes
  input  wire          WR_SET_A,
  input  wire          WR_RESET_A,
  input  wire          WR_SET_B,
  input  wire          WR_RESET_B,
  input  wire          WR_OUTPUT_CONFIG,
  input  wire          WR_OUTPUT_MATRIX,
  input  wire [CW-1:0] WR_DATA,
  // Events
  input  wire          RETRIGGER,
  input  wire          FAULT,
  // Interrupt control
  input  wire [2:0]    FLAG_CLEAR,
  input  wire [2:0]    IRQ_ENABLE,
  // Waveform pins
  output wire          WAVE_OUT_A,
  output wire          WAVE_OUT_B,
  output wire          WAVE_OUT_DUP2,
  output wire          WAVE_OUT_DUP3,
  // Synchronisation
  output wire          SYNC_OUTPUT,
  output wire          CONVERTER_SYNC_PULSE,
  output wire          CHAIN_STOP_OUTPUT,
  // Status
  output wire [CW-1:0] CAPTURE_VALUE,
  output wire [2:0]    EVENT_FLAGS,
  output wire          IRQ_REQUEST,
  output wire [7:0]    OUTPUT_MATRIX,
  output wire          UPDATE_PENDING
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Pin level from raw wave, enable and polarity; disabled pins sit inactive
  function drive_level;
    input wave;
    input en;
    input pol;
    begin
      drive_level = (en & wave) ^ pol;
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg           run_q;
  reg           auto_update_hold_q;
  reg           pending_q;
  reg           rb_written_q;
  reg [3:0]     pin_q;
  reg           sync_q;
  reg           conv_sync_q;
  reg           stop_q;
  reg [CW-1:0]  capture_q;
  reg [2:0]     flag_q;
  reg           irq_q;

  wire [3:0]      wr_cmp;
  wire [4*CW-1:0] cmp_staged;
  wire [4*CW-1:0] cmp_active;
  wire [4*CW-1:0] cmp_load_data;
  wire [7:0]      ocfg_staged;
  wire [7:0]      ocfg;
  wire [7:0]      omat_staged;
  wire            any_wr;
  wire            load;
  wire [CW-1:0]   cnt_val;
  wire [1:0]      ramp;
  wire            eoc;
  wire            wave_a;
  wire            wave_b;
  wire [3:0]      pin_wave;
  wire [3:0]      pin_en;
  wire [3:0]      pin_pol;
  wire [2:0]      flag_set;

  wire [CW-1:0] set_a   = cmp_active[0*CW +: CW];
  wire [CW-1:0] reset_a = cmp_active[1*CW +: CW];
  wire [CW-1:0] set_b   = cmp_active[2*CW +: CW];
  wire [CW-1:0] reset_b = cmp_active[3*CW +: CW];

  assign wr_cmp = {WR_RESET_B, WR_SET_B, WR_RESET_A, WR_SET_A};
  assign any_wr = (|wr_cmp) | WR_OUTPUT_CONFIG | WR_OUTPUT_MATRIX;

  // ****************************************************************
  // Update control
  // ****************************************************************
  // Stopped: load every cycle so writes land at once
  // Running: only at end of cycle, gated by lock or auto-lock
  assign load = !run_q ? 1'b1 :
                (eoc & (auto_update_hold_q ? rb_written_q : (!LOCK & pending_q)));

  always @(posedge CLK) begin
    if (RESET) begin
      run_q        <= 1'b0;
      auto_update_hold_q   <= 1'b0;
      pending_q    <= 1'b0;
      rb_written_q <= 1'b0;
    end else begin
      // Dropping RUN aborts the cycle; raising it starts a fresh one
      run_q <= RUN;
      if (!run_q || eoc) begin
        auto_update_hold_q <= AUTO_UPDATE_HOLD;
      end
      // A write in the loading cycle stays pending for the next cycle
      pending_q    <= any_wr | (pending_q & ~load);
      rb_written_q <= WR_RESET_B | (rb_written_q & ~load);
    end
  end

  // ****************************************************************
  // Buffered waveform registers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
      // Part A slots take part B values in fifty-percent mode
      if (gi < 2) begin : g_part_a
        assign cmp_load_data[gi*CW +: CW] = FIFTY_PERCENT ? cmp_staged[(gi+2)*CW +: CW]
                                                           : cmp_staged[gi*CW +: CW];
      end else begin : g_part_b
        assign cmp_load_data[gi*CW +: CW] = cmp_staged[gi*CW +: CW];
      end
      pswg_shadow #(
        .W   (CW),
        .RST (`PSWG_CMP_RST)
      ) u_cmp (
        .clk       (CLK),
        .reset     (RESET),
        .wr        (wr_cmp[gi]),
        .wdata     (WR_DATA),
        .load      (load),
        .load_data (cmp_load_data[gi*CW +: CW]),
        .staged    (cmp_staged[gi*CW +: CW]),
        .active    (cmp_active[gi*CW +: CW])
      );
    end
  endgenerate

  pswg_shadow #(
    .W   (`PSWG_CFG_W),
    .RST (`PSWG_CFG_RST)
  ) u_ocfg (
    .clk       (CLK),
    .reset     (RESET),
    .wr        (WR_OUTPUT_CONFIG),
    .wdata     (WR_DATA[7:0]),
    .load      (load),
    .load_data (ocfg_staged),
    .staged    (ocfg_staged),
    .active    (ocfg)
  );

  pswg_shadow #(
    .W   (`PSWG_CFG_W),
    .RST (`PSWG_CFG_RST)
  ) u_omat (
    .clk       (CLK),
    .reset     (RESET),
    .wr        (WR_OUTPUT_MATRIX),
    .wdata     (WR_DATA[7:0]),
    .load      (load),
    .load_data (omat_staged),
    .staged    (omat_staged),
    .active    (OUTPUT_MATRIX)
  );

  // ****************************************************************
  // Counter and compares
  // ****************************************************************
  pswg_ramp #(
    .CW (CW)
  ) u_ramp (
    .clk     (CLK),
    .reset   (RESET),
    .run     (run_q),
    .mode    (MODE),
    .set_a   (set_a),
    .reset_a (reset_a),
    .set_b   (set_b),
    .reset_b (reset_b),
    .cnt_val (cnt_val),
    .ramp    (ramp),
    .eoc     (eoc),
    .wave_a  (wave_a),
    .wave_b  (wave_b)
  );

  // ****************************************************************
  // Output pins
  // ****************************************************************
  assign pin_wave = {ocfg[`PSWG_OCFG_SEL_DUP3] ? wave_b : wave_a,
                     ocfg[`PSWG_OCFG_SEL_DUP2] ? wave_b : wave_a,
                     wave_b,
                     wave_a};
  assign pin_en   = {ocfg[`PSWG_OCFG_EN_DUP3], ocfg[`PSWG_OCFG_EN_DUP2],
                     ocfg[`PSWG_OCFG_EN_B], ocfg[`PSWG_OCFG_EN_A]};
  // Duplicates follow the polarity of the part they copy
  assign pin_pol  = {ocfg[`PSWG_OCFG_SEL_DUP3] ? ocfg[`PSWG_OCFG_POL_B] : ocfg[`PSWG_OCFG_POL_A],
                     ocfg[`PSWG_OCFG_SEL_DUP2] ? ocfg[`PSWG_OCFG_POL_B] : ocfg[`PSWG_OCFG_POL_A],
                     ocfg[`PSWG_OCFG_POL_B],
                     ocfg[`PSWG_OCFG_POL_A]};

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      always @(posedge CLK) begin
        if (RESET) begin
          pin_q[gi] <= 1'b0;
        end else begin
          pin_q[gi] <= drive_level(pin_wave[gi], pin_en[gi], pin_pol[gi]);
        end
      end
    end
  endgenerate

  assign WAVE_OUT_A    = pin_q[0];
  assign WAVE_OUT_B    = pin_q[1];
  assign WAVE_OUT_DUP2 = pin_q[2];
  assign WAVE_OUT_DUP3 = pin_q[3];

  // ****************************************************************
  // Synchronisation outputs
  // ****************************************************************
  always @(posedge CLK) begin
    if (RESET) begin
      sync_q      <= 1'b0;
      conv_sync_q <= 1'b0;
      stop_q      <= 1'b1;
    end else begin
      sync_q <= eoc;
      stop_q <= ~run_q;
      if (MODE == `PSWG_MODE_CENTER) begin
        // Reset-A marks a point on the down ramp only
        conv_sync_q <= run_q & (ramp == `PSWG_RAMP_0) & (cnt_val == reset_a);
      end else begin
        conv_sync_q <= eoc;
      end
    end
  end

  assign SYNC_OUTPUT          = sync_q;
  assign CONVERTER_SYNC_PULSE = conv_sync_q;
  assign CHAIN_STOP_OUTPUT    = stop_q;

  // ****************************************************************
  // Capture and interrupt
  // ****************************************************************
  assign flag_set = {RETRIGGER & run_q, FAULT, eoc};

  always @(posedge CLK) begin
    if (RESET) begin
      capture_q <= `PSWG_CMP_RST;
      flag_q    <= 3'h0;
      irq_q     <= 1'b0;
    end else begin
      if (flag_set[`PSWG_FLAG_CAPT]) begin
        capture_q <= cnt_val;
      end
      // A new event beats a clear in the same cycle
      flag_q <= flag_set | (flag_q & ~FLAG_CLEAR);
      irq_q  <= |(flag_q & IRQ_ENABLE);
    end
  end

  assign CAPTURE_VALUE  = capture_q;
  assign EVENT_FLAGS    = flag_q;
  assign IRQ_REQUEST    = irq_q;
  assign UPDATE_PENDING = pending_q;

endmodule // pswg_top

// File: verification/pswg_bridge_model.sv
`timescale 1ns/1ps
module pswg_bridge_model (
  // Clock and clear
  input  wire        clk,
  input  wire        clr,
  // Gate drives
  input  wire        hi_gate,
  input  wire        lo_gate,
  // Measurements
  output reg  [15:0] on_hi,
  output reg  [15:0] on_lo,
  output reg  [15:0] period_hi,
  output reg         overlap
);
  // ****************************************************************
  // Gate timing monitor
  // ****************************************************************
  reg        hi_q;
  reg        lo_q;
  reg [15:0] run_hi_q;
  reg [15:0] run_lo_q;
  reg [15:0] per_q;
  always @(posedge clk) begin
    if (clr) begin
      hi_q      <= 1'b0;
      lo_q      <= 1'b0;
      run_hi_q  <= 16'h0000;
      run_lo_q  <= 16'h0000;
      per_q     <= 16'h0000;
      on_hi     <= 16'h0000;
      on_lo     <= 16'h0000;
      period_hi <= 16'h0000;
      overlap   <= 1'b0;
    end else begin
      hi_q     <= hi_gate;
      lo_q     <= lo_gate;
      run_hi_q <= hi_gate ? run_hi_q + 16'h0001 : 16'h0000;
      run_lo_q <= lo_gate ? run_lo_q + 16'h0001 : 16'h0000;
      if (hi_q && !hi_gate)
        on_hi <= run_hi_q;
      if (lo_q && !lo_gate)
        on_lo <= run_lo_q;
      per_q <= (hi_gate && !hi_q) ? 16'h0001 : per_q + 16'h0001;
      if (hi_gate && !hi_q)
        period_hi <= per_q;
      // Both switches on would short a real half bridge
      if (hi_gate && lo_gate)
        overlap <= 1'b1;
    end
  end
endmodule // pswg_bridge_model

// File: verification/pswg_top_assertions.sv
`timescale 1ns/1ps
module pswg_checker #(
  parameter CW = 12
) (
  // Clock and control
  input wire          CLK,
  input wire          RESET,
  input wire          RUN,
  input wire          FAULT,
  input wire          RETRIGGER,
  input wire [2:0]    FLAG_CLEAR,
  input wire [2:0]    IRQ_ENABLE,
  // Writes
  input wire          WR_SET_B,
  input wire          WR_OUTPUT_MATRIX,
  input wire [CW-1:0] WR_DATA,
  // Observed outputs
  input wire          WAVE_OUT_A,
  input wire          WAVE_OUT_B,
  input wire          SYNC_OUTPUT,
  input wire          CHAIN_STOP_OUTPUT,
  input wire [2:0]    EVENT_FLAGS,
  input wire          IRQ_REQUEST,
  input wire [7:0]    OUTPUT_MATRIX,
  input wire          UPDATE_PENDING
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  reset_idle_pins_a: assert property (disable iff (1'b0)
    RESET |=> !WAVE_OUT_A && !WAVE_OUT_B && CHAIN_STOP_OUTPUT && EVENT_FLAGS == 3'h0)
    else $error("pins not idle after reset");
  irq_follows_flags_a: assert property (
    IRQ_REQUEST == |($past(EVENT_FLAGS) & $past(IRQ_ENABLE))) else $error("irq not masked flags");
  fault_sets_flag_a: assert property (
    FAULT |=> EVENT_FLAGS[1]) else $error("fault flag not set");
  // Retrigger counts only while the registered run bit is high, one cycle behind RUN
  capture_sets_flag_a: assert property (
    RETRIGGER && $past(RUN) && !$past(RESET) |=> EVENT_FLAGS[2]) else $error("capture flag not set");
  fault_flag_sticky_a: assert property (
    EVENT_FLAGS[1] && !FLAG_CLEAR[1] |=> EVENT_FLAGS[1]) else $error("fault flag lost");
  capture_flag_clear_a: assert property (
    FLAG_CLEAR[2] && !RETRIGGER |=> !EVENT_FLAGS[2]) else $error("capture flag not cleared");
  sync_single_pulse_a: assert property (
    SYNC_OUTPUT |=> !SYNC_OUTPUT) else $error("sync pulse too long");
  stop_after_halt_a: assert property (
    $fell(RUN) ##1 !RUN [*2] |-> CHAIN_STOP_OUTPUT) else $error("stop status missing");
  write_sets_pending_a: assert property (
    WR_SET_B && !RUN && !$past(RUN) |=> UPDATE_PENDING) else $error("write not staged");
  // Stopped writes land one edge after staging, ahead of any restart
  stopped_write_lands_a: assert property (
    WR_OUTPUT_MATRIX && !RUN && !$past(RUN) ##1 !WR_OUTPUT_MATRIX |=> OUTPUT_MATRIX == $past(WR_DATA[7:0], 2))
    else $error("stopped write not applied");
endmodule // pswg_checker

bind pswg_top pswg_checker #(.CW(CW)) u_chk (.CLK(CLK), .RESET(RESET), .RUN(RUN), .FAULT(FAULT),
  .RETRIGGER(RETRIGGER), .FLAG_CLEAR(FLAG_CLEAR), .IRQ_ENABLE(IRQ_ENABLE), .WR_SET_B(WR_SET_B),
  .WR_OUTPUT_MATRIX(WR_OUTPUT_MATRIX), .WR_DATA(WR_DATA), .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B),
  .SYNC_OUTPUT(SYNC_OUTPUT), .CHAIN_STOP_OUTPUT(CHAIN_STOP_OUTPUT), .EVENT_FLAGS(EVENT_FLAGS),
  .IRQ_REQUEST(IRQ_REQUEST), .OUTPUT_MATRIX(OUTPUT_MATRIX), .UPDATE_PENDING(UPDATE_PENDING));

// File: verification/pswg_top_tb.sv
`timescale 1ns/1ps
`include "pswg_defines.vh"
module pswg_top_tb;
  // ****************************************************************
  // Stimulus, instances and tasks
  // ****************************************************************
  localparam [11:0] SA = 12'h0002;
  localparam [11:0] RA = 12'h0006;
  localparam [11:0] SB = 12'h0003;
  localparam [11:0] RB = 12'h0009;
  localparam [11:0] SB2 = 12'h0004;
  localparam [11:0] RB2 = 12'h0007;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         run = 1'b0;
  reg  [1:0]  mode = 2'h0;
  reg         fifty = 1'b0;
  reg         lock = 1'b0;
  reg         auto_hold = 1'b0;
  reg  [5:0]  wr_sel = 6'h00;
  reg  [11:0] wr_data = 12'h0000;
  reg  [4:0]  ev = 5'h00;
  reg  [2:0]  irq_en = 3'h0;
  reg         clr_m = 1'b1;
  wire        wa, wb, wd2, wd3, sync, csp, stop, irq, pend, ovl;
  wire [11:0] cap;
  wire [2:0]  flags;
  wire [7:0]  matrix;
  wire [15:0] on_a, on_b, per_a;
  integer     n_fail = 0;
  integer     total_checks = 0;
  integer     m;
  reg  [15:0] ea, eb, ep;

  always #5 clk = ~clk;

  pswg_top #(.CW(12)) dut (.CLK(clk), .RESET(reset), .RUN(run), .MODE(mode), .FIFTY_PERCENT(fifty),
    .LOCK(lock), .AUTO_UPDATE_HOLD(auto_hold), .WR_SET_A(wr_sel[0]), .WR_RESET_A(wr_sel[1]),
    .WR_SET_B(wr_sel[2]), .WR_RESET_B(wr_sel[3]), .WR_OUTPUT_CONFIG(wr_sel[4]),
    .WR_OUTPUT_MATRIX(wr_sel[5]), .WR_DATA(wr_data), .RETRIGGER(ev[0]), .FAULT(ev[1]),
    .FLAG_CLEAR(ev[4:2]), .IRQ_ENABLE(irq_en), .WAVE_OUT_A(wa), .WAVE_OUT_B(wb), .WAVE_OUT_DUP2(wd2),
    .WAVE_OUT_DUP3(wd3), .SYNC_OUTPUT(sync), .CONVERTER_SYNC_PULSE(csp), .CHAIN_STOP_OUTPUT(stop),
    .CAPTURE_VALUE(cap), .EVENT_FLAGS(flags), .IRQ_REQUEST(irq), .OUTPUT_MATRIX(matrix),
    .UPDATE_PENDING(pend));

  pswg_bridge_model bridge (.clk(clk), .clr(clr_m), .hi_gate(wa), .lo_gate(wb), .on_hi(on_a),
    .on_lo(on_b), .period_hi(per_a), .overlap(ovl));

  task tally_and_finish;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask

  // Index 0..5: set A, reset A, set B, reset B, output config, output matrix
  task wr(input integer i, input [11:0] v);
    begin
      @(posedge clk);
      wr_sel <= 6'h01 << i;
      wr_data <= v;
      @(posedge clk);
      wr_sel <= 6'h00;
    end
  endtask

  task go(input r);
    begin
      @(posedge clk);
      run <= r;
      clr_m <= ~r;
    end
  endtask

  // Sync pulses last one cycle, so each negedge sample counts a cycle end once
  task wait_sync(input integer n);
    integer k;
    begin
      k = 0;
      while (n > 0) begin
        @(negedge clk);
        k = k + 1;
        if (sync === 1'b1)
          n = n - 1;
        if (k > 400) begin
          n_fail = n_fail + 1;
          tally_and_finish;
        end
      end
    end
  endtask

  task ev_pulse(input [4:0] v);
    begin
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 5'h00;
      @(posedge clk);
      @(negedge clk);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("stop", 16'h0001, stop);
    chk("pins", 16'h0000, {wa, wb, wd2, wd3});
    chk("capture", 16'h0000, cap);
    wr(4, 12'h0030);
    for (m = 0; m < 4; m = m + 1) begin
      @(posedge clk);
      mode <= m[1:0];
      wr(0, SA);
      wr(1, RA);
      wr(2, SB);
      wr(3, RB);
      go(1'b1);
      wait_sync(3);
      case (m)
        0: begin ea = RA; eb = RB; ep = RA + RB + SA + SB + 4; end
        1: begin ea = RA - SA; eb = RB - SB; ep = RA + RB + 2; end
        2: begin ea = RA - SA; eb = RB - SB; ep = RB + 1; end
        default: begin ea = 2 * SA; eb = 2 * (RB - SB + 1); ep = 2 * (RB + 1); end
      endcase
      chk("on time a", ea, on_a);
      chk("on time b", eb, on_b);
      chk("period", ep, per_a);
      chk("overlap", m == 2, ovl);
      chk("stop", 16'h0000, stop);
      if (m == 3)
        repeat (RB - RA + 1) @(negedge clk);
      chk("converter sync", 16'h0001, csp);
      go(1'b0);
    end
    @(posedge clk);
    mode <= `PSWG_MODE_TWO;
    go(1'b1);
    wait_sync(1);
    wr(5, 12'h00A5);
    @(negedge clk);
    chk("matrix held", 16'h0000, matrix);
    chk("pending", 16'h0001, pend);
    wait_sync(1);
    chk("matrix", 16'h00A5, matrix);
    chk("pending", 16'h0000, pend);
    @(posedge clk);
    lock <= 1'b1;
    wr(5, 12'h003C);
    wait_sync(2);
    chk("matrix locked", 16'h00A5, matrix);
    @(posedge clk);
    lock <= 1'b0;
    wait_sync(1);
    chk("matrix released", 16'h003C, matrix);
    @(posedge clk);
    auto_hold <= 1'b1;
    wr(5, 12'h0081);
    wait_sync(1);
    chk("matrix first", 16'h0081, matrix);
    @(posedge clk);
    lock <= 1'b1;
    wr(5, 12'h00C3);
    wait_sync(2);
    chk("matrix held", 16'h0081, matrix);
    wr(3, RB);
    wait_sync(1);
    chk("matrix auto", 16'h00C3, matrix);
    @(posedge clk);
    auto_hold <= 1'b0;
    lock <= 1'b0;
    go(1'b0);
    @(posedge clk);
    mode <= `PSWG_MODE_FOUR;
    fifty <= 1'b1;
    wr(5, 12'h005A);
    repeat (2) @(negedge clk);
    chk("matrix stopped", 16'h005A, matrix);
    wr(4, 12'h00F6);
    wr(2, SB2);
    wr(3, RB2);
    go(1'b1);
    wait_sync(3);
    chk("fifty on a", RB2, on_a);
    chk("inactive b", 2 * SB2 + 4 + RB2, on_b);
    chk("fifty period", 2 * (RB2 + SB2 + 2), per_a);
    repeat (30) begin
      @(negedge clk);
      chk("dup2", wb, wd2);
      chk("dup3", wa, wd3);
    end
    @(posedge clk);
    irq_en <= 3'h4;
    // Retrigger lands one count into ramp 0, so the captured value is known
    wait_sync(1);
    ev_pulse(5'h01);
    chk("capture flag", 16'h0001, flags[2]);
    chk("irq", 16'h0001, irq);
    chk("capture", 16'h0001, cap);
    ev_pulse(5'h02);
    chk("fault flag", 16'h0001, flags[1]);
    ev_pulse(5'h10);
    chk("capture cleared", 16'h0000, flags[2]);
    chk("irq masked", 16'h0000, irq);
    chk("overflow flag", 16'h0001, flags[0]);
    go(1'b0);
    tally_and_finish;
  end
endmodule // pswg_top_tb
